// ==== rtl/cbp_pkg.sv ====
// Constants and carriers for the command block parser.
// Assumes one clock domain and 32-bit memory words.
package cbp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_START = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_ISTAT = 8'h0C;
    localparam logic [7:0] OFS_IMASK = 8'h10;
    localparam logic [7:0] OFS_CUR = 8'h14;
    // Field positions
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_DEV_BIT = 1;
    localparam int EV_DONE_BIT = 0;
    localparam int EV_IGN_BIT = 1;
    localparam int EV_HOST_BIT = 2;
    localparam int END_BIT = 63;
    // Reset values
    localparam logic [31:0] START_RST = 32'h0000_0000;
    localparam logic [2:0] IMASK_RST = 3'h0;
    // Header layout in words, response byte values
    localparam logic [9:0] HDR_WORDS = 10'h004;
    localparam logic [7:0] RESP_DONE = 8'h01;
    localparam logic [7:0] RESP_IGN = 8'h05;

    typedef struct packed {
        logic [1:0] rsvd;
        logic drive_select_toggle_flag;
        logic wide_io_reserved_flag;
        logic completion_irq_enable;
        logic descriptor_valid_flag;
        logic queued_command_flag;
        logic block_valid_flag;
    } ctrl_flags_t;

    typedef struct packed {
        logic last;
        logic wait_not_busy_bit;
        logic entry_skip_bit;
        logic [4:0] reg_sel;
        logic [7:0] value;
    } command_entry_t;
endpackage : cbp_pkg

// ==== rtl/cbp_engine.sv ====
// Command block fetch, decode and command issue engine with APB registers.
// Assumes a word-read port and a byte-write port into host memory, a
// device register write port, and a not-busy pin from the device.
// Function
// - Valid and not complete: execute the block's command entries.
// - Not valid and not complete: skip, write complete and ignored flags.
// - Descriptor valid flag marks the descriptor pointer as usable.
// - Completion interrupt only when the block's irq enable bit is one.
// - Toggle drive select after successful command when toggle flag set.
// - Byte 3 gives the command-data quadword count to fetch.
// - First quadword upper word is the next block address, followed.
// - Second quadword low word is the first descriptor address.
// - Each data quadword yields four 16-bit entries, low first.
// - Response byte is written only by the adapter; host zeroes it.
// - Entry: write low byte to selected register; skip bit; wait not busy.
// - Bit 63 marks the final entry; issue ends after it.
`timescale 1ns/1ps
module cbp_engine
    import cbp_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic MRD_REQ,
    output logic [31:0] MRD_ADDR,
    input wire logic MRD_ACK,
    input wire logic [31:0] MRD_DATA,
    output logic MWR_REQ,
    output logic [31:0] MWR_ADDR,
    output logic [7:0] MWR_BYTE,
    input wire logic MWR_ACK,
    output logic DREG_VALID,
    output logic [4:0] DREG_ADDR,
    output logic [7:0] DREG_DATA,
    input wire logic DREG_READY,
    input wire logic DEV_NOT_BUSY,
    input wire logic CMD_OK,
    input wire logic CMD_ERR,
    output logic DESC_VALID,
    output logic [31:0] DESC_ADDR,
    output logic QUEUED,
    output logic DEV,
    output logic IRQ
);
    // ********************************
    // State and storage
    // ********************************
    typedef enum logic [8:0] {
        S_IDLE = 9'h001, S_FETCH = 9'h002, S_DECIDE = 9'h004,
        S_ENTRY = 9'h008, S_WAIT_NB = 9'h010, S_ISSUE = 9'h020,
        S_WAIT_CMD = 9'h040, S_WBACK = 9'h080, S_NEXT = 9'h100
    } state_t;
    state_t st_q, st_d;
    ctrl_flags_t ctl_q;
    logic [7:0] resp_q, len_q, wb_q;
    logic [31:0] base_q, next_q, desc_q, start_q, lo_q;
    logic [63:0] quad_q;
    logic [9:0] widx_q;
    logic [1:0] ent_q;
    logic run_q, dev_q, nb_m_q, nb_q;
    logic [2:0] ist_q, imask_q;

    // ********************************
    // Decode
    // ********************************
    command_entry_t cur_ent;
    logic wr, rd_hit, is_data, quad_hi, last_quad, issue_ok;
    logic ent_last, blk_end, cmd_fin, ev_done, ev_ign, ev_host;
    logic [2:0] ev_set;
    logic [9:0] end_widx;

    assign wr = PSEL && PENABLE && PWRITE;
    assign cur_ent = command_entry_t'(quad_q[{ent_q, 4'h0} +: 16]);
    assign is_data = widx_q >= HDR_WORDS;
    assign quad_hi = widx_q[0];
    assign end_widx = HDR_WORDS + {1'b0, len_q, 1'b0};
    assign last_quad = (widx_q == end_widx);
    assign issue_ok = (st_q == S_ISSUE) && DREG_READY;
    assign ent_last = (ent_q == 2'd3);
    assign blk_end = quad_q[END_BIT] || last_quad;
    assign cmd_fin = (st_q == S_WAIT_CMD) && (CMD_OK || CMD_ERR);
    assign ev_done = cmd_fin && ctl_q.completion_irq_enable;
    assign ev_ign = (st_q == S_DECIDE) && !ctl_q.block_valid_flag && !resp_q[0];
    assign ev_host = (st_q == S_DECIDE) && resp_q[0];
    assign ev_set = {ev_host, ev_ign, ev_done};

    // ********************************
    // Sequencer
    // ********************************
    always_comb begin
        st_d = st_q;
        case (st_q)
            S_IDLE: if (run_q) st_d = S_FETCH;
            S_FETCH: begin
                if (MRD_ACK) begin
                    if (widx_q == HDR_WORDS - 10'd1) st_d = S_DECIDE;
                    else if (is_data && quad_hi) st_d = S_ENTRY;
                end
            end
            S_DECIDE: begin
                if (resp_q[0]) st_d = S_IDLE;
                else if (!ctl_q.block_valid_flag) st_d = S_WBACK;
                else if (len_q == 8'h00) st_d = S_WAIT_CMD;
                else st_d = S_FETCH;
            end
            S_ENTRY: begin
                if (cur_ent.entry_skip_bit) begin
                    if (ent_last) st_d = blk_end ? S_WAIT_CMD : S_FETCH;
                end else if (cur_ent.wait_not_busy_bit) st_d = S_WAIT_NB;
                else st_d = S_ISSUE;
            end
            S_WAIT_NB: if (nb_q) st_d = S_ISSUE;
            S_ISSUE: begin
                if (DREG_READY) begin
                    if (!ent_last) st_d = S_ENTRY;
                    else st_d = blk_end ? S_WAIT_CMD : S_FETCH;
                end
            end
            S_WAIT_CMD: if (CMD_OK || CMD_ERR) st_d = S_WBACK;
            S_WBACK: if (MWR_ACK) st_d = S_NEXT;
            S_NEXT: st_d = run_q ? S_FETCH : S_IDLE;
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) st_q <= S_IDLE;
        else st_q <= st_d;
    end

    // ********************************
    // Fetch and decode datapath
    // ********************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            widx_q <= 10'h000;
            ent_q <= 2'd0;
            base_q <= START_RST;
            ctl_q <= '0;
            resp_q <= 8'h00;
            len_q <= 8'h00;
            next_q <= 32'h0;
            desc_q <= 32'h0;
            lo_q <= 32'h0;
            quad_q <= 64'h0;
            wb_q <= 8'h00;
        end else begin
            if (st_q == S_IDLE && run_q) begin
                base_q <= start_q;
                widx_q <= 10'h000;
            end
            if (st_q == S_FETCH && MRD_ACK) begin
                widx_q <= widx_q + 10'd1;
                case (widx_q)
                    10'd0: begin
                        resp_q <= MRD_DATA[7:0];
                        ctl_q <= ctrl_flags_t'(MRD_DATA[23:16]);
                        len_q <= MRD_DATA[31:24];
                    end
                    10'd1: next_q <= MRD_DATA;
                    10'd2: desc_q <= MRD_DATA;
                    default: ;
                endcase
                if (is_data && !quad_hi) lo_q <= MRD_DATA;
                if (is_data && quad_hi) begin
                    quad_q <= {MRD_DATA, lo_q};
                    ent_q <= 2'd0;
                end
            end
            if ((st_q == S_ENTRY && cur_ent.entry_skip_bit) || issue_ok) begin
                ent_q <= ent_q + 2'd1;
            end
            if (st_q == S_DECIDE) wb_q <= RESP_IGN;
            if (cmd_fin) wb_q <= RESP_DONE;
            if (st_q == S_NEXT) begin
                base_q <= next_q;
                widx_q <= 10'h000;
            end
        end
    end

    // ********************************
    // Pins, host and device side
    // ********************************
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            nb_m_q <= 1'b0;
            nb_q <= 1'b0;
        end else begin
            nb_m_q <= DEV_NOT_BUSY;
            nb_q <= nb_m_q;
        end
    end

    assign MRD_REQ = (st_q == S_FETCH);
    assign MRD_ADDR = base_q + {20'h0, widx_q, 2'b00};
    assign MWR_REQ = (st_q == S_WBACK);
    assign MWR_ADDR = base_q;
    assign MWR_BYTE = wb_q;
    assign DREG_VALID = (st_q == S_ISSUE);
    assign DREG_ADDR = cur_ent.reg_sel;
    assign DREG_DATA = cur_ent.value;
    assign DESC_VALID = ctl_q.descriptor_valid_flag;
    assign DESC_ADDR = desc_q;
    assign QUEUED = ctl_q.queued_command_flag;
    assign DEV = dev_q;
    assign IRQ = |(ist_q & imask_q);

    // ********************************
    // APB registers and interrupts
    // ********************************
    assign rd_hit = (PADDR == OFS_CTRL) || (PADDR == OFS_START) ||
                    (PADDR == OFS_STAT) || (PADDR == OFS_ISTAT) ||
                    (PADDR == OFS_IMASK) || (PADDR == OFS_CUR);
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !rd_hit;

    always_comb begin
        case (PADDR)
            OFS_CTRL: PRDATA = {30'h0, dev_q, run_q};
            OFS_START: PRDATA = start_q;
            OFS_STAT: PRDATA = {23'h0, st_q};
            OFS_ISTAT: PRDATA = {29'h0, ist_q};
            OFS_IMASK: PRDATA = {29'h0, imask_q};
            OFS_CUR: PRDATA = base_q;
            default: PRDATA = 32'h0;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            run_q <= 1'b0;
            dev_q <= 1'b0;
            start_q <= START_RST;
            imask_q <= IMASK_RST;
            ist_q <= 3'h0;
        end else begin
            if (wr && PADDR == OFS_CTRL) begin
                run_q <= PWDATA[CTRL_RUN_BIT];
                dev_q <= PWDATA[CTRL_DEV_BIT];
            end
            if (cmd_fin && CMD_OK && ctl_q.drive_select_toggle_flag) begin
                dev_q <= !dev_q;
            end
            if (wr && PADDR == OFS_START) start_q <= PWDATA;
            if (wr && PADDR == OFS_IMASK) imask_q <= PWDATA[2:0];
            // Set wins over a same-cycle write-one clear
            ist_q <= (ist_q & ~((wr && PADDR == OFS_ISTAT) ? PWDATA[2:0] : 3'h0))
                     | ev_set;
        end
    end

    // ********************************
    // Checks
    // ********************************
    property p_exec;
        @(posedge REF_CLK) disable iff (RST)
        st_q == S_DECIDE && ctl_q.block_valid_flag && !resp_q[0] && len_q != 8'h00
        |=> st_q == S_FETCH ##0 MRD_ADDR == base_q + 32'h10;
    endproperty
    a_exec: assert property (p_exec) else $error("valid block not executed");

    property p_skip;
        @(posedge REF_CLK) disable iff (RST)
        st_q == S_DECIDE && !ctl_q.block_valid_flag && !resp_q[0]
        |=> MWR_REQ && MWR_BYTE == RESP_IGN && !DREG_VALID;
    endproperty
    a_skip: assert property (p_skip) else $error("invalid block not skipped");

    property p_irq;
        @(posedge REF_CLK) disable iff (RST)
        cmd_fin && ctl_q.completion_irq_enable |=> ist_q[EV_DONE_BIT];
    endproperty
    a_irq: assert property (p_irq) else $error("completion event lost");

    property p_noirq;
        @(posedge REF_CLK) disable iff (RST)
        cmd_fin && !ctl_q.completion_irq_enable && !ist_q[EV_DONE_BIT] |=> !ist_q[EV_DONE_BIT];
    endproperty
    a_noirq: assert property (p_noirq) else $error("completion event not suppressed");

    property p_flip;
        @(posedge REF_CLK) disable iff (RST)
        st_q == S_WAIT_CMD && CMD_ERR && !wr |=> $stable(DEV);
    endproperty
    a_flip: assert property (p_flip) else $error("drive select changed on error");

    property p_order;
        @(posedge REF_CLK) disable iff (RST)
        issue_ok && !ent_last |=> ent_q == $past(ent_q) + 2'd1;
    endproperty
    a_order: assert property (p_order) else $error("entries out of order");

    property p_ign;
        @(posedge REF_CLK) disable iff (RST)
        st_q == S_ENTRY && cur_ent.entry_skip_bit |=> st_q != S_ISSUE && st_q != S_WAIT_NB;
    endproperty
    a_ign: assert property (p_ign) else $error("skipped entry issued");

    property p_wnb;
        @(posedge REF_CLK) disable iff (RST)
        st_q == S_WAIT_NB && !nb_q |=> !DREG_VALID;
    endproperty
    a_wnb: assert property (p_wnb) else $error("write while busy");

    property p_end;
        @(posedge REF_CLK) disable iff (RST)
        issue_ok && ent_last && quad_q[END_BIT] |=> st_q == S_WAIT_CMD;
    endproperty
    a_end: assert property (p_end) else $error("issue went past end");

    property p_next;
        @(posedge REF_CLK) disable iff (RST)
        st_q == S_NEXT && run_q |=> MRD_REQ && MRD_ADDR == $past(next_q);
    endproperty
    a_next: assert property (p_next) else $error("next block not followed");

    property p_wb;
        @(posedge REF_CLK) disable iff (RST)
        MWR_REQ && MWR_ACK |=> st_q == S_NEXT ##1 !MWR_REQ;
    endproperty
    a_wb: assert property (p_wb) else $error("write-back sequence wrong");
endmodule : cbp_engine

// ==== verification/host_side_model.sv ====
// Host memory and device side model for the command block parser.
// Assumes one clock and host memory below 512 bytes.
`timescale 1ns/1ps
module host_side_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] rnd,
    input wire logic mrd_req,
    input wire logic [31:0] mrd_addr,
    output logic mrd_ack,
    output logic [31:0] mrd_data,
    input wire logic mwr_req,
    input wire logic [31:0] mwr_addr,
    input wire logic [7:0] mwr_byte,
    output logic mwr_ack,
    input wire logic dreg_valid,
    output logic dreg_ready,
    output logic not_busy,
    output logic cmd_ok,
    output logic cmd_err
);
    logic [31:0] mem [0:127];
    logic [31:0] word;
    logic [2:0] quiet;
    logic err;
    assign word = mem[mrd_addr[8:2]];
    // Command ends after a quiet spell; fails once a block was skipped
    assign cmd_ok = quiet == 3'h5 && !err;
    assign cmd_err = quiet == 3'h5 && err;
    always @(posedge clk) begin
        not_busy <= rnd[3];
        if (rst) begin
            mrd_ack <= 1'b0;
            mwr_ack <= 1'b0;
            dreg_ready <= 1'b0;
            quiet <= 3'h0;
            err <= 1'b0;
        end else begin
            mrd_ack <= mrd_req && !mrd_ack && rnd[0];
            mwr_ack <= mwr_req && !mwr_ack && rnd[1];
            dreg_ready <= dreg_valid && !dreg_ready && rnd[2];
            quiet <= (mrd_req || mwr_req || dreg_valid) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
            err <= err || (mwr_req && mwr_ack && mwr_byte == 8'h05);
        end
        // Released data lines show the inverse word
        mrd_data <= (mrd_req && !mrd_ack && rnd[0]) ? word : ~word;
        if (mwr_req && mwr_ack) begin
            mem[mwr_addr[8:2]][7:0] <= mwr_byte;
        end
    end
endmodule : host_side_model

// ==== verification/command_block_descriptor_parser_bench.sv ====
// Self-checking bench for the command block parser.
// Assumes host_side_model as memory and device partner.
`timescale 1ns/1ps
module command_block_descriptor_parser_bench;
    import cbp_pkg::*;
    typedef struct packed {
        logic mw;
        logic [31:0] adr;
        logic [7:0] dat;
        logic dev;
        logic q;
        logic dv;
        logic [31:0] da;
        logic full;
    } note_t;
    localparam logic [31:0] DA = 32'h1230_0008;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, e_bit;
    logic [7:0] padr = 8'h00;
    logic [31:0] pwd = 32'h0, seed = 32'h5B, scatter_descriptor, rdv, mrd_data, desc_addr, mrd_addr, mwr_addr;
    logic [3:0] rnd = 4'h0;
    logic pready, pslverr, mrd_req, mrd_ack, mwr_req, mwr_ack, dvld, drdy, nbusy, cok, cerr;
    logic desc_valid, queued, dev, irq;
    logic [7:0] mwr_byte, ddat, rv;
    logic [4:0] dadr;
    note_t q_exp[$];
    logic wi;
    logic wi_exp[$];
    note_t ne, ns;
    int bad_count = 0, cmp_count = 0;
    always #2.5 clk = ~clk;
    cbp_engine i_dut (
        .REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
        .PWDATA(pwd), .PRDATA(scatter_descriptor), .PREADY(pready), .PSLVERR(pslverr), .MRD_REQ(mrd_req),
        .MRD_ADDR(mrd_addr), .MRD_ACK(mrd_ack), .MRD_DATA(mrd_data), .MWR_REQ(mwr_req),
        .MWR_ADDR(mwr_addr), .MWR_BYTE(mwr_byte), .MWR_ACK(mwr_ack), .DREG_VALID(dvld),
        .DREG_ADDR(dadr), .DREG_DATA(ddat), .DREG_READY(drdy), .DEV_NOT_BUSY(nbusy),
        .CMD_OK(cok), .CMD_ERR(cerr), .DESC_VALID(desc_valid), .DESC_ADDR(desc_addr),
        .QUEUED(queued), .DEV(dev), .IRQ(irq));
    host_side_model i_host (
        .clk(clk), .rst(rst), .rnd(rnd), .mrd_req(mrd_req), .mrd_addr(mrd_addr),
        .mrd_ack(mrd_ack), .mrd_data(mrd_data), .mwr_req(mwr_req), .mwr_addr(mwr_addr),
        .mwr_byte(mwr_byte), .mwr_ack(mwr_ack), .dreg_valid(dvld), .dreg_ready(drdy),
        .not_busy(nbusy), .cmd_ok(cok), .cmd_err(cerr));
    // ****************
    // Tasks
    // ****************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic chk(input string nm, input logic [76:0] s, input logic [76:0] e);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdv = scatter_descriptor;
        e_bit = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            stop_test();
        end
    endtask : apb
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, {45'h0, rdv}, {45'h0, x});
    endtask : rd
    task automatic pn(input logic mw, input logic [31:0] a, input logic [7:0] d,
                      input logic [2:0] f, input logic [31:0] da, input logic full);
        q_exp.push_back('{mw, a, d, f[2], f[1], f[0], da, full});
    endtask : pn
    // ****************
    // Scoreboard and sequence
    // ****************
    always @(posedge clk) begin
        seed <= xs(seed);
        rnd <= seed[3:0];
        if (!rst && ((dvld && drdy) || (mwr_req && mwr_ack))) begin
            ns = '{mwr_ack, mwr_ack ? mwr_addr : {27'h0, dadr}, mwr_ack ? mwr_byte : ddat,
                   dev, queued, desc_valid, desc_addr, 1'b1};
            ne = (q_exp.size() == 0) ? '1 : q_exp.pop_front();
            if (!ne.full) begin
                ns = '{ns.mw, ns.adr, ns.dat, ns.dev, ne.q, ne.dv, ne.da, 1'b0};
            end
            chk("transfer", ns, ne);
            if (mwr_req && mwr_ack) begin
                wi = (wi_exp.size() == 0) ? 1'bx : wi_exp.pop_front();
                chk("wb_irq", {76'h0, irq}, {76'h0, wi});
            end
        end
    end
    initial begin
        for (int i = 0; i < 128; i++) begin
            i_host.mem[i] = 32'h0;
        end
        rv = seed[11:4];
        i_host.mem[16] = 32'h0227_0000;
        i_host.mem[17] = 32'h0000_0080;
        i_host.mem[18] = DA;
        i_host.mem[20] = {16'h22FF, 8'h01, rv};
        i_host.mem[21] = 32'h0311_423C;
        i_host.mem[22] = 32'h2000_2000;
        i_host.mem[23] = 32'h87EC_2000;
        i_host.mem[33] = 32'h0000_00C0;
        i_host.mem[48] = 32'h0029_0000;
        i_host.mem[49] = 32'h0000_0100;
        i_host.mem[64] = 32'h0009_0001;
        i_host.mem[65] = 32'h0000_0040;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd("int_mask", OFS_IMASK, {29'h0, IMASK_RST});
        rd("start", OFS_START, START_RST);
        pn(1'b0, 32'h01, rv, 3'h3, DA, 1'b1);
        pn(1'b0, 32'h02, 8'h3C, 3'h3, DA, 1'b1);
        pn(1'b0, 32'h03, 8'h11, 3'h3, DA, 1'b1);
        pn(1'b0, 32'h07, 8'hEC, 3'h3, DA, 1'b1);
        pn(1'b1, 32'h40, RESP_DONE, 3'h7, DA, 1'b1);
        pn(1'b1, 32'h80, RESP_IGN, 3'h4, DA, 1'b0);
        pn(1'b1, 32'hC0, RESP_DONE, 3'h4, 32'h0, 1'b1);
        wi_exp.push_back(1'b0);
        wi_exp.push_back(1'b0);
        wi_exp.push_back(1'b1);
        apb(1'b1, OFS_IMASK, 32'h1);
        apb(1'b1, OFS_START, 32'h40);
        apb(1'b1, OFS_CTRL, 32'h1);
        for (int n = 0; n < 4000 && q_exp.size() > 0; n++) begin
            @(posedge clk);
        end
        if (q_exp.size() > 0) begin
            bad_count++;
            stop_test();
        end
        repeat (40) @(posedge clk);
        rd("ctrl", OFS_CTRL, 32'h3);
        apb(1'b1, OFS_CTRL, 32'h0);
        repeat (40) @(posedge clk);
        rd("status", OFS_STAT, 32'h1);
        rd("int_status", OFS_ISTAT, 32'h7);
        chk("irq", {76'h0, irq}, 77'h1);
        apb(1'b1, OFS_IMASK, 32'h2);
        @(posedge clk);
        chk("irq", {76'h0, irq}, 77'h1);
        apb(1'b1, OFS_ISTAT, 32'h2);
        @(posedge clk);
        chk("irq", {76'h0, irq}, 77'h0);
        rd("int_status", OFS_ISTAT, 32'h5);
        apb(1'b0, 8'hFC, 32'h0);
        chk("unmapped", {44'h0, e_bit, rdv}, 77'h1_0000_0000);
        stop_test();
    end
endmodule : command_block_descriptor_parser_bench
